// *** common/audio_routing_defines.vh ***
// Contract
// [R1] core input 0 selector in bits 3:0, reset 0, codes 0-3 pick input 0-3
// [R2] core input 1 selector in bits 7:4 of same register, reset 1
// [R3] core input 2 selector in bits 3:0 of second register, reset 2
// [R4] core input 3 selector in bits 7:4 of second register, reset 3
// [R5] any selector code 1100 routes rate converter channel 0
// [R6] any selector code 1101 routes rate converter channel 1
// [R7] low pair register at offset 0x0F, resets to 0x10
// [R8] high pair register at offset 0x10, resets to 0x32
// [R9] converter select at 0x11, reset 0x10, upper nibble converter 1
// [R10] converter selector codes 0-2 route core outputs 0-2
// [R11] code 3 routes core output 3; update applies only while core stopped
// [R12] software must not change converter selection while core runs
// [R13] codes 0100-1011 are not written; device passes silence for them
// [R14] changed selector applies only at a sample boundary
`ifndef AUDIO_ROUTING_DEFINES_VH
`define AUDIO_ROUTING_DEFINES_VH

// ------------------------------------------------------------------
// register indices, byte address is index times four
// ------------------------------------------------------------------
`define IDX_CORE_IN_LOW   6'h0F
`define IDX_CORE_IN_HIGH  6'h10
`define IDX_CONV_SRC      6'h11
`define IDX_CONTROL       6'h14
`define IDX_STATUS        6'h15

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define RST_CORE_IN_LOW   8'h10
`define RST_CORE_IN_HIGH  8'h32
`define RST_CONV_SRC      8'h10
`define RST_CONTROL       8'h00

// ------------------------------------------------------------------
// field positions and source codes
// ------------------------------------------------------------------
`define FLD_LO_MSB        3
`define FLD_HI_LSB        4
`define CTRL_CORE_RUN     0
`define CODE_ASRC0        4'hC
`define CODE_ASRC1        4'hD
`define CODE_LAST_DIRECT  4'h3

`endif

// *** hdl/sample_fifo.v ***
// ------------------------------------------------------------------
// synchronous sample fifo
// ------------------------------------------------------------------
module sample_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,     // clock
    input  wire             rst,     // async reset, high
    input  wire [WIDTH-1:0] in_data, // write data
    input  wire             in_valid,// write request
    output wire             in_ready,// not full
    output wire [WIDTH-1:0] out_data,// head word
    output wire             out_valid,// not empty
    input  wire             out_ready // read accept
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wptr;
    reg [AW:0]      rptr;
    wire            do_wr;
    wire            do_rd;

    // full when pointers differ only in wrap bit
    assign in_ready  = (wptr ^ rptr) != {1'b1, {AW{1'b0}}};
    assign out_valid = wptr != rptr;
    assign do_wr     = in_valid & in_ready;
    assign do_rd     = out_valid & out_ready;
    assign out_data  = mem[rptr[AW-1:0]];

    // storage has no reset, only pointers do
    always @(posedge clk) begin
        if (do_wr) begin
            mem[wptr[AW-1:0]] <= in_data;
        end
    end

    // pointer update
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wptr <= {(AW+1){1'b0}};
            rptr <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wptr <= wptr + 1'b1;
            end
            if (do_rd) begin
                rptr <= rptr + 1'b1;
            end
        end
    end
endmodule // sample_fifo

// *** hdl/source_mux.v ***
// ------------------------------------------------------------------
// one routing selector: picks a source sample by code
// ------------------------------------------------------------------
`include "audio_routing_defines.vh"
module source_mux #(
    parameter WIDTH = 24
) (
    input  wire [3:0]         sel,   // source code
    input  wire [4*WIDTH-1:0] direct,// four direct sources, lane n = code n
    input  wire [WIDTH-1:0]   asrc0, // rate converter channel 0
    input  wire [WIDTH-1:0]   asrc1, // rate converter channel 1
    output reg  [WIDTH-1:0]   out    // selected sample
);
    // reserved codes give silence rather than stale data
    always @* begin
        case (sel)
            4'h0: out = direct[WIDTH-1:0];
            4'h1: out = direct[2*WIDTH-1:WIDTH];
            4'h2: out = direct[3*WIDTH-1:2*WIDTH];
            4'h3: out = direct[4*WIDTH-1:3*WIDTH];
            `CODE_ASRC0: out = asrc0;          // see [R5]
            `CODE_ASRC1: out = asrc1;          // see [R6]
            default: out = {WIDTH{1'b0}};      // see [R13]
        endcase
    end
endmodule // source_mux

// *** hdl/audio_source_routing_select.v ***
// Our own choice: register access over APB.
`include "audio_routing_defines.vh"
// ------------------------------------------------------------------
// audio source routing select: registers, muxes, output fifo
// ------------------------------------------------------------------
module audio_source_routing_select #(
    parameter WIDTH = 24,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire               CLK,        // 125 MHz clock
    input  wire               RST,        // async reset, high
    // apb slave
    input  wire               PSEL,       // select
    input  wire               PENABLE,    // access phase
    input  wire               PWRITE,     // write
    input  wire [7:0]         PADDR,      // byte address
    input  wire [31:0]        PWDATA,     // write data
    output reg  [31:0]        PRDATA,     // read data
    output reg                PREADY,     // ready
    output reg                PSLVERR,    // unmapped address
    // sample sources
    input  wire               SAMPLE_STROBE, // one pulse per sample
    input  wire [4*WIDTH-1:0] INPUT_CH,   // input channels 0..3
    input  wire [4*WIDTH-1:0] CORE_OUT,   // core outputs 0..3
    input  wire [WIDTH-1:0]   ASRC_CH0,   // rate converter ch 0
    input  wire [WIDTH-1:0]   ASRC_CH1,   // rate converter ch 1
    // routed core inputs
    output reg  [4*WIDTH-1:0] CORE_IN,    // core input channels 0..3
    output reg                CORE_IN_VALID, // pulse per sample
    // routed converter stream, one frame of both converters per word
    output reg  [2*WIDTH-1:0] CONV_DATA,  // {conv1, conv0}
    output reg                CONV_VALID, // word present
    input  wire               CONV_READY, // sink accepts
    output reg                CORE_RUN,   // core run control
    output reg                OVERRUN     // sample lost, fifo full
);
    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    reg  [7:0] core_input_select_low_pair;
    reg  [7:0] core_input_select_high_pair;
    reg  [7:0] output_converter_source_select;
    reg  [7:0] ctrl;
    // shadows that the datapath really uses
    reg  [7:0] low_shadow;
    reg  [7:0] high_shadow;
    reg  [7:0] conv_shadow;
    reg        conv_pending;
    reg        in_pending;
    reg        fifo_full_seen;

    wire       setup   = PSEL & ~PENABLE;
    wire [5:0] widx    = PADDR[7:2];
    wire       wr_ok;

    // index lookup used only for the PSLVERR decode of reads and writes
    function mapped;
        input [5:0] idx;
        begin
            mapped = (idx == `IDX_CORE_IN_LOW) ||
                     (idx == `IDX_CORE_IN_HIGH) ||
                     (idx == `IDX_CONV_SRC) ||
                     (idx == `IDX_CONTROL) ||
                     (idx == `IDX_STATUS);
        end
    endfunction

    // write takes effect at the access edge with pready high
    assign wr_ok = PSEL & PENABLE & PREADY & PWRITE;

    // ------------------------------------------------------------------
    // apb handshake: no wait state, ready in first access cycle
    // ------------------------------------------------------------------
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end else begin
            PREADY  <= setup;
            PSLVERR <= setup & ~mapped(widx);
            if (setup & ~PWRITE) begin
                case (widx)
                    `IDX_CORE_IN_LOW:
                        PRDATA <= {24'h000000, core_input_select_low_pair};
                    `IDX_CORE_IN_HIGH:
                        PRDATA <= {24'h000000, core_input_select_high_pair};
                    `IDX_CONV_SRC:
                        PRDATA <= {24'h000000,
                                   output_converter_source_select};
                    `IDX_CONTROL:
                        PRDATA <= {24'h000000, ctrl};
                    `IDX_STATUS:
                        PRDATA <= {28'h0000000, fifo_full_seen,
                                   conv_pending, in_pending, CORE_RUN};
                    default:
                        PRDATA <= 32'h00000000;
                endcase
            end
        end
    end

    // software-visible registers
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            core_input_select_low_pair     <= `RST_CORE_IN_LOW;  // see [R7]
            core_input_select_high_pair    <= `RST_CORE_IN_HIGH; // see [R8]
            output_converter_source_select <= `RST_CONV_SRC;     // see [R9]
            ctrl                           <= `RST_CONTROL;
        end else if (wr_ok) begin
            case (widx)
                `IDX_CORE_IN_LOW:  core_input_select_low_pair  <= PWDATA[7:0];
                `IDX_CORE_IN_HIGH: core_input_select_high_pair <= PWDATA[7:0];
                `IDX_CONV_SRC:
                    output_converter_source_select <= PWDATA[7:0];
                `IDX_CONTROL:      ctrl <= PWDATA[7:0];
                default:           ctrl <= ctrl;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // shadow update at sample boundaries
    // ------------------------------------------------------------------
    // core inputs switch only on a sample strobe, so no torn sample;
    // converter sources additionally wait for the core to be stopped,
    // a running core keeps the old route until software stops it
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            low_shadow   <= `RST_CORE_IN_LOW;
            high_shadow  <= `RST_CORE_IN_HIGH;
            conv_shadow  <= `RST_CONV_SRC;
            CORE_RUN     <= 1'b0;
            in_pending   <= 1'b0;
            conv_pending <= 1'b0;
        end else begin
            CORE_RUN <= ctrl[`CTRL_CORE_RUN];
            if (SAMPLE_STROBE) begin
                low_shadow  <= core_input_select_low_pair;   // see [R14]
                high_shadow <= core_input_select_high_pair;  // see [R14]
            end
            if (SAMPLE_STROBE & ~CORE_RUN) begin
                conv_shadow <= output_converter_source_select; // see [R11]
            end
            in_pending <= (low_shadow != core_input_select_low_pair) |
                          (high_shadow != core_input_select_high_pair);
            conv_pending <= conv_shadow != output_converter_source_select;
        end
    end

    // ------------------------------------------------------------------
    // routing muxes
    // ------------------------------------------------------------------
    wire [WIDTH-1:0] core_in_sel [0:3];
    wire [WIDTH-1:0] conv_sel    [0:1];
    wire [15:0]      in_codes = {high_shadow, low_shadow};

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_core_in
            // nibble g: ch0 [3:0], ch1 [7:4], ch2/ch3 second register
            source_mux #(.WIDTH(WIDTH)) u_mux (
                .sel    (in_codes[4*g+3:4*g]), // see [R1] [R2] [R3] [R4]
                .direct (INPUT_CH),
                .asrc0  (ASRC_CH0),
                .asrc1  (ASRC_CH1),
                .out    (core_in_sel[g])
            );
        end
        for (g = 0; g < 2; g = g + 1) begin : g_conv
            // converter 0 low nibble, converter 1 high nibble
            source_mux #(.WIDTH(WIDTH)) u_mux (
                .sel    (conv_shadow[4*g+3:4*g]), // see [R9] [R10] [R11]
                .direct (CORE_OUT),
                .asrc0  (ASRC_CH0),
                .asrc1  (ASRC_CH1),
                .out    (conv_sel[g])
            );
        end
    endgenerate

    // core input registers, one update per sample
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            CORE_IN       <= {4*WIDTH{1'b0}};
            CORE_IN_VALID <= 1'b0;
        end else begin
            CORE_IN_VALID <= SAMPLE_STROBE;
            if (SAMPLE_STROBE) begin
                CORE_IN <= {core_in_sel[3], core_in_sel[2],
                            core_in_sel[1], core_in_sel[0]};
            end
        end
    end

    // ------------------------------------------------------------------
    // converter fifo and registered output stage
    // ------------------------------------------------------------------
    wire               fifo_in_ready;
    wire [2*WIDTH-1:0] fifo_head;
    wire               fifo_head_valid;
    wire               stage_take;

    // output stage refills when empty or when the sink takes the word
    assign stage_take = fifo_head_valid & (~CONV_VALID | CONV_READY);

    sample_fifo #(.WIDTH(2*WIDTH), .DEPTH(DEPTH), .AW(AW)) u_fifo (
        .clk       (CLK),
        .rst       (RST),
        .in_data   ({conv_sel[1], conv_sel[0]}),
        .in_valid  (SAMPLE_STROBE),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_head),
        .out_valid (fifo_head_valid),
        .out_ready (stage_take)
    );

    // samples arriving to a full fifo are dropped and flagged,
    // the audio clock cannot be stalled by a slow sink
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            CONV_DATA      <= {2*WIDTH{1'b0}};
            CONV_VALID     <= 1'b0;
            OVERRUN        <= 1'b0;
            fifo_full_seen <= 1'b0;
        end else begin
            if (stage_take) begin
                CONV_DATA  <= fifo_head;
                CONV_VALID <= 1'b1;
            end else if (CONV_READY) begin
                CONV_VALID <= 1'b0;
            end
            OVERRUN <= SAMPLE_STROBE & ~fifo_in_ready;
            // sticky, set wins over clear by write to status
            if (SAMPLE_STROBE & ~fifo_in_ready) begin
                fifo_full_seen <= 1'b1;
            end else if (wr_ok && widx == `IDX_STATUS) begin
                fifo_full_seen <= 1'b0;
            end
        end
    end
endmodule // audio_source_routing_select

// *** verification/audio_routing_properties.sv ***
module audio_routing_properties #(
    parameter WIDTH = 24
) (
    input logic               CLK,           // clock
    input logic               RST,           // async reset
    input logic               PSEL,          // select
    input logic               PENABLE,       // access phase
    input logic               PWRITE,        // write
    input logic [7:0]         PADDR,         // byte address
    input logic [31:0]        PWDATA,        // write data
    input logic [31:0]        PRDATA,        // read data
    input logic               PREADY,        // ready
    input logic               PSLVERR,       // error
    input logic               SAMPLE_STROBE, // sample pulse
    input logic               CORE_IN_VALID, // routed sample
    input logic [2*WIDTH-1:0] CONV_DATA,     // converter word
    input logic               CONV_VALID,    // word present
    input logic               CONV_READY,    // sink accepts
    input logic               CORE_RUN,      // run control
    input logic               OVERRUN        // sample lost
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mapped;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // --------
    // bus
    // --------
    assign mapped = PADDR inside {8'h3C, 8'h40, 8'h44, 8'h50, 8'h54};
    sequence s_setup; PSEL && !PENABLE; endsequence
    sequence s_take; PSEL && PENABLE && PREADY; endsequence
    property p_answer; s_setup |=> s_take; endproperty
    property p_ready; PREADY |-> PSEL && PENABLE; endproperty
    property p_unmap;
        s_setup ##0 !mapped |=> PSLVERR && (PWRITE || PRDATA == 32'h0);
    endproperty
    property p_map; s_setup ##0 mapped |=> !PSLVERR; endproperty
    property p_narrow; PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0; endproperty
    property p_run;
        s_take ##0 (PWRITE && PADDR == 8'h50) |->
            ##2 CORE_RUN == $past(PWDATA[0], 2);
    endproperty
    a_answer: assert property (p_answer)
        else $error("no ready after setup");
    a_ready: assert property (p_ready)
        else $error("ready outside access");
    a_unmap: assert property (p_unmap)
        else $error("unmapped access not refused");
    a_map: assert property (p_map)
        else $error("mapped access refused");
    a_narrow: assert property (p_narrow)
        else $error("upper read bits set");
    a_run: assert property (p_run)
        else $error("run control not applied");
    // --------
    // samples
    // --------
    property p_strobe; SAMPLE_STROBE |=> CORE_IN_VALID; endproperty
    property p_cause; CORE_IN_VALID |-> $past(SAMPLE_STROBE); endproperty
    property p_push; SAMPLE_STROBE |-> ##[1:2] CONV_VALID; endproperty
    property p_hold;
        CONV_VALID && !CONV_READY |=> CONV_VALID && $stable(CONV_DATA);
    endproperty
    property p_ovr; OVERRUN |-> $past(SAMPLE_STROBE) && $past(CONV_VALID);
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("no routed sample after strobe");
    a_cause: assert property (p_cause)
        else $error("routed sample without strobe");
    a_push: assert property (p_push)
        else $error("converter word missing");
    a_hold: assert property (p_hold)
        else $error("converter word changed while stalled");
    a_ovr: assert property (p_ovr)
        else $error("overrun without full push");
endmodule // audio_routing_properties

bind audio_source_routing_select audio_routing_properties
    #(.WIDTH(WIDTH)) props_u (.*);

// *** verification/audio_far_end.sv ***
module audio_far_end (
    input  logic        clk,    // clock
    input  logic        rst,    // async reset
    input  logic        go,     // request one sample
    input  logic        stall,  // sink stalls
    output logic        strobe, // sample pulse
    output logic [15:0] k,      // samples taken
    output logic [95:0] ain,    // input channels
    output logic [95:0] cout,   // core outputs
    output logic [23:0] a0,     // rate converter 0
    output logic [23:0] a1,     // rate converter 1
    output logic        ready   // sink accepts
);
    timeunit 1ns;
    timeprecision 1ps;
    // lanes carry kind, index and count so misroutes show
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            ain[24*n +: 24]  = {4'h1, 4'(n), k};
            cout[24*n +: 24] = {4'h2, 4'(n), k};
        end
    end
    assign a0    = {8'h30, k};
    assign a1    = {8'h31, k};
    assign ready = !stall;
    // count moves on as the strobe is taken, so stale data shows
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strobe <= 1'b0;
            k      <= 16'h0000;
        end else begin
            strobe <= go;
            if (strobe)
                k <= k + 16'h0001;
        end
    end
endmodule // audio_far_end

// *** verification/audio_source_routing_select_tb_top.sv ***
module audio_source_routing_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic        PREADY, PSLVERR, CORE_IN_VALID, CONV_VALID, CORE_RUN;
    logic        OVERRUN, go = 0, stall = 0, strobe, ready, er, vg, cg;
    logic [95:0] ain, cout, CORE_IN, ci;
    logic [47:0] CONV_DATA, cv;
    logic [23:0] a0, a1;
    logic [15:0] k, kk;
    logic [3:0]  c;
    logic [3:0]  codes [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hC, 4'hD};
    int          errors = 0, n_tests = 0, cyc = 0, novr = 0, nd = 0;

    audio_source_routing_select dut_u (.CLK(CLK), .RST(RST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .SAMPLE_STROBE(strobe), .INPUT_CH(ain), .CORE_OUT(cout),
        .ASRC_CH0(a0), .ASRC_CH1(a1), .CORE_IN(CORE_IN),
        .CORE_IN_VALID(CORE_IN_VALID), .CONV_DATA(CONV_DATA),
        .CONV_VALID(CONV_VALID), .CONV_READY(ready), .CORE_RUN(CORE_RUN),
        .OVERRUN(OVERRUN));
    audio_far_end far_u (.clk(CLK), .rst(RST), .go(go), .stall(stall),
        .strobe(strobe), .k(k), .ain(ain), .cout(cout), .a0(a0), .a1(a1),
        .ready(ready));

    // --------
    // tasks
    // --------
    always #4 CLK = ~CLK;
    // hang guard, run needs a few hundred cycles
    always @(posedge CLK) begin
        cyc++;
        if (OVERRUN === 1'b1)
            novr++;
        if (cyc == 20000) begin
            errors++;
            close_out;
        end
    end
    task automatic close_out;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [95:0] e, s);
        n_tests++;
        if (e !== s) begin
            errors++;
            $display("mismatch %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    function automatic logic [23:0] src(input logic [3:0] s,
                                        input logic [15:0] q, input logic o);
        return s < 4 ? {o ? 4'h2 : 4'h1, s, q} : s == 4'hC ? {8'h30, q} :
               s == 4'hD ? {8'h31, q} : 24'h0;
    endfunction
    // one sample; want waits for its converter word too
    task automatic samp(input logic want);
        @(posedge CLK);
        go <= 1'b1;
        @(posedge CLK);
        go <= 1'b0;
        vg = 0;
        cg = 0;
        repeat (40) begin
            @(posedge CLK);
            if (CORE_IN_VALID === 1'b1) begin
                ci = CORE_IN;
                kk = k - 16'h0001;
                vg = 1;
            end
            if (CONV_VALID === 1'b1 && ready) begin
                cv = CONV_DATA;
                cg = 1;
            end
            if (vg && (cg || !want))
                break;
        end
        // a sample that never shows would leave stale words to compare
        chk("sample seen", 96'h1,
            {95'h0, vg && (cg || !want)});
    endtask
    // selectors act one strobe after they are loaded
    task automatic route(input logic [7:0] lo, hi, cs);
        samp(1);
        samp(1);
        chk("core_in", {src(hi[7:4], kk, 0), src(hi[3:0], kk, 0),
            src(lo[7:4], kk, 0), src(lo[3:0], kk, 0)}, ci);
        chk("conv", {48'h0, src(cs[7:4], kk, 1), src(cs[3:0], kk, 1)},
            {48'h0, cv});
    endtask

    // --------
    // tests
    // --------
    initial begin
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        apb(0, 8'h3C, 0);
        chk("low pair", 96'h10, {64'h0, rd});
        apb(0, 8'h40, 0);
        chk("high pair", 96'h32, {64'h0, rd});
        apb(0, 8'h44, 0);
        chk("conv sel", 96'h10, {64'h0, rd});
        route(8'h10, 8'h32, 8'h10);
        // reserved codes are never written
        foreach (codes[i]) begin
            c = codes[i];
            apb(1, 8'h3C, {24'h0, c, c ^ 4'h1});
            apb(1, 8'h40, {24'h0, c ^ 4'h1, c});
            apb(1, 8'h44, {24'h0, c, c ^ 4'h1});
            apb(0, 8'h40, 0);
            chk("readback", {88'h0, c ^ 4'h1, c}, {64'h0, rd});
            route({c, c ^ 4'h1}, {c ^ 4'h1, c}, {c, c ^ 4'h1});
        end
        apb(1, 8'h44, 32'h10);
        route(8'hDC, 8'hCD, 8'h10);
        // new route written while stopped, core started before any strobe,
        // so the selection is never changed under a running core
        apb(1, 8'h44, 32'h32);
        apb(1, 8'h50, 32'h1);
        route(8'hDC, 8'hCD, 8'h10);
        chk("run", 96'h1, {95'h0, CORE_RUN});
        apb(0, 8'h54, 0);
        chk("status", 96'h5, {92'h0, rd[3:0]});
        apb(1, 8'h50, 32'h0);
        route(8'hDC, 8'hCD, 8'h32);
        apb(1, 8'h48, 32'hFF);
        chk("err wr", 96'h1, {95'h0, er});
        apb(0, 8'h48, 0);
        chk("err rd", 96'h1, {63'h0, rd, er});
        stall <= 1'b1;
        repeat (18) samp(0);
        apb(0, 8'h54, 0);
        chk("sticky", 96'h1, {95'h0, rd[3]});
        stall <= 1'b0;
        repeat (80) begin
            @(posedge CLK);
            if (CONV_VALID === 1'b1)
                nd++;
        end
        chk("kept+lost", 96'h12, 96'(nd + novr));
        chk("overrun", 96'h1, {95'h0, novr != 0});
        close_out;
    end
endmodule // audio_source_routing_select_tb_top
